// ===== core/bicd_core.sv
// Command decoder for a four-channel analog sensor input module.
// Assumes a byte stream from the gateway with a one-cycle valid, and a calibration memory that answers reads.
`timescale 1ns/100ps
module bicd_core
  import bicd_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic rsp_ready_i,
  input wire logic [NCH*32-1:0] conv_word_i,
  input wire logic [NCH*8-1:0] sample_num_i,
  input wire logic [7:0] nvm_rdata_i,
  input wire logic nvm_rvalid_i,
  output logic [7:0] rsp_byte_o,
  output logic rsp_valid_o,
  output logic busy_o,
  output logic common_valid_o,
  output logic [7:0] common_byte_o,
  output logic [NCH*5-1:0] conv_cfg_o,
  output logic [7:0] excitation_o,
  output logic [NCH*4-1:0] exc_onehot_o,
  output logic nvm_rd_o,
  output logic nvm_wr_o,
  output logic [7:0] nvm_addr_o,
  output logic [7:0] nvm_wdata_o
);
  // Four channels are documented; the packing of the excitation byte fixes this.
  initial begin
    if (NCH != 4) begin
      $error("bicd_core supports exactly four channels");
    end
  end

  // Whole module state in one packed struct.
  typedef struct packed {
    bicd_state_e st;
    logic is_rd;
    logic [1:0] chan;
    logic [2:0] cfg_cnt;
    logic [31:0] cfg;
    logic [4:0] rsp_idx;
    logic [4:0] rsp_len;
    logic [NCH*32-1:0] snap_w;
    logic [NCH*8-1:0] snap_n;
    logic [7:0] rsp_byte;
    logic rsp_valid;
    logic com_valid;
    logic [7:0] com_byte;
    bicd_conv_s [NCH-1:0] conv;
    logic [7:0] exc;
    logic [NCH*4-1:0] exc_oh;
    bicd_nvm_s nvm;
    // Registered busy flag, so that the busy output comes from a flip-flop.
    logic busy;
  } bicd_reg_s;

  bicd_reg_s cur; // Registered state.
  bicd_reg_s next_cur; // Next value.

  // Maps an oversample code to a compact index; zero marks an unsupported code.
  function automatic logic [3:0] osr_index(input logic [11:0] code);
    if (code >= `BICD_OSR_CODE_LO && code <= `BICD_OSR_CODE_HI) begin
      osr_index = code[3:0];
    end else if (code == `BICD_OSR_CODE_MAX) begin
      osr_index = `BICD_OSR_IDX_MAX;
    end else begin
      osr_index = 4'h0;
    end
  endfunction : osr_index

  // Builds a conversion word so the top two bits are always clear.
  function automatic logic [31:0] fmt_word(input logic [31:0] raw);
    fmt_word = {2'b00, raw[29], raw[28:0]};
  endfunction : fmt_word

  // Picks the reply byte at a given position of the readout message.
  function automatic logic [7:0] readout_byte(input bicd_reg_s s, input logic [4:0] idx);
    logic [31:0] w;
    w = 32'h0;
    if (idx < `BICD_WORD_BYTES) begin
      w = fmt_word(s.snap_w[idx[3:2]*32 +: 32]);
      readout_byte = w[idx[1:0]*8 +: 8];
    end else begin
      readout_byte = s.snap_n[idx[1:0]*8 +: 8];
    end
  endfunction : readout_byte

  // Next-state logic for the decoder.
  always_comb begin
    next_cur = cur;
    next_cur.rsp_valid = 1'b0;
    next_cur.com_valid = 1'b0;
    next_cur.nvm.rd = 1'b0;
    next_cur.nvm.wr = 1'b0;
    case (cur.st)
      // Waiting for an opcode byte.
      BICD_IDLE: begin
        if (cmd_valid_i) begin
          case (cmd_byte_i)
            `BICD_OP_CONV_CFG: next_cur.st = BICD_CHAN;
            `BICD_OP_READOUT: begin
              // Snapshot keeps the reply coherent while it streams out.
              next_cur.snap_w = conv_word_i;
              next_cur.snap_n = sample_num_i;
              next_cur.rsp_idx = 5'h00;
              next_cur.rsp_len = `BICD_READOUT_LEN;
              next_cur.is_rd = 1'b0;
              next_cur.st = BICD_SEND;
            end
            `BICD_OP_EXC_SEL: next_cur.st = BICD_EXC;
            `BICD_OP_NVM_RD: begin
              next_cur.is_rd = 1'b1;
              next_cur.st = BICD_ADDR;
            end
            `BICD_OP_NVM_WR: begin
              next_cur.is_rd = 1'b0;
              next_cur.st = BICD_ADDR;
            end
            default: begin
              // Other opcodes go to the shared common-action logic untouched.
              next_cur.com_valid = 1'b1;
              next_cur.com_byte = cmd_byte_i;
            end
          endcase
        end
      end
      // Channel byte; upper bits are the sender's to keep clear.
      BICD_CHAN: begin
        if (cmd_valid_i) begin
          next_cur.chan = cmd_byte_i[`BICD_CHAN_MSB:0];
          next_cur.cfg_cnt = 3'h0;
          next_cur.st = BICD_CFG;
        end
      end
      // Four configuration bytes, least significant first.
      BICD_CFG: begin
        if (cmd_valid_i) begin
          next_cur.cfg = {cmd_byte_i, cur.cfg[31:8]};
          next_cur.cfg_cnt = cur.cfg_cnt + 3'h1;
          if (cur.cfg_cnt == `BICD_CFG_BYTES - 3'h1) begin
            // The shifted copy already holds the whole value, so fields are taken at their own positions.
            // Low bits are reserved and simply ignored here; a sender that sets them changes nothing.
            next_cur.conv[cur.chan].osr_idx = osr_index(next_cur.cfg[`BICD_OSR_MSB:`BICD_OSR_LSB]);
            next_cur.conv[cur.chan].speed_mult = next_cur.cfg[`BICD_SPEED_BIT];
            next_cur.st = BICD_IDLE;
          end
        end
      end
      // Single excitation byte updates all channels at once.
      BICD_EXC: begin
        if (cmd_valid_i) begin
          next_cur.exc = cmd_byte_i;
          for (int i = 0; i < NCH; i++) begin
            next_cur.exc_oh[i*4 +: 4] = 4'h1 << cmd_byte_i[i*2 +: 2];
          end
          next_cur.st = BICD_IDLE;
        end
      end
      // Memory address byte.
      BICD_ADDR: begin
        if (cmd_valid_i) begin
          next_cur.nvm.addr = cmd_byte_i;
          if (cur.is_rd) begin
            next_cur.nvm.rd = 1'b1;
            next_cur.rsp_len = 5'h01;
            next_cur.rsp_idx = 5'h00;
            next_cur.st = BICD_SEND;
          end else begin
            next_cur.st = BICD_DATA;
          end
        end
      end
      // Memory write data byte.
      BICD_DATA: begin
        if (cmd_valid_i) begin
          next_cur.nvm.data = cmd_byte_i;
          next_cur.nvm.wr = 1'b1;
          next_cur.st = BICD_IDLE;
        end
      end
      // Streams the reply; a memory read waits for its data.
      BICD_SEND: begin
        if (rsp_ready_i && !cur.rsp_valid) begin
          if (cur.is_rd) begin
            if (nvm_rvalid_i) begin
              next_cur.rsp_byte = nvm_rdata_i;
              next_cur.rsp_valid = 1'b1;
              next_cur.is_rd = 1'b0;
              next_cur.st = BICD_IDLE;
            end
          end else begin
            next_cur.rsp_byte = readout_byte(cur, cur.rsp_idx);
            next_cur.rsp_valid = 1'b1;
            next_cur.rsp_idx = cur.rsp_idx + 5'h01;
            if (cur.rsp_idx == cur.rsp_len - 5'h01) begin
              next_cur.st = BICD_IDLE;
            end
          end
        end
      end
      default: next_cur.st = BICD_IDLE;
    endcase
    // Busy follows the next state, so it falls on the edge that ends the action.
    next_cur.busy = (next_cur.st != BICD_IDLE);
  end

  // State register; every reset source arrives on rst_i.
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.exc <= `BICD_EXC_RESET;
      cur.exc_oh <= {NCH{4'h1}};
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from the state flip-flops.
  assign rsp_byte_o = cur.rsp_byte;
  assign rsp_valid_o = cur.rsp_valid;
  assign busy_o = cur.busy;
  assign common_valid_o = cur.com_valid;
  assign common_byte_o = cur.com_byte;
  assign conv_cfg_o = cur.conv;
  assign excitation_o = cur.exc;
  assign exc_onehot_o = cur.exc_oh;
  assign nvm_rd_o = cur.nvm.rd;
  assign nvm_wr_o = cur.nvm.wr;
  assign nvm_addr_o = cur.nvm.addr;
  assign nvm_wdata_o = cur.nvm.data;

  // Replies never exceed the message limit.
  AST_RSP_LEN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cur.rsp_len <= `BICD_RSP_MAX) else $error("reply length too large");
  // Top bits of the sent word are zero.
  AST_TOP_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_SEND && !cur.is_rd && rsp_ready_i && !cur.rsp_valid && cur.rsp_idx[1:0] == 2'h3
     && cur.rsp_idx < `BICD_WORD_BYTES) |=> rsp_valid_o && rsp_byte_o[7:6] == 2'b00)
    else $error("conversion word top bits set");
  // Excitation changes only through its action.
  AST_EXC_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st != BICD_EXC) |=> $stable(excitation_o)) else $error("excitation changed");
  // Write pulse follows the data byte.
  AST_NVM_WR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_DATA && cmd_valid_i) |=> nvm_wr_o && nvm_wdata_o == $past(cmd_byte_i))
    else $error("memory write missing");
  // Unknown opcode leaves settings alone.
  AST_UNKNOWN: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_IDLE && cmd_valid_i && cmd_byte_i > `BICD_OP_NVM_WR) |=>
    common_valid_o && $stable(conv_cfg_o) && !nvm_wr_o) else $error("unknown opcode acted");
  // Read opcode then address yields a read strobe.
  AST_NVM_RD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_ADDR && cur.is_rd && cmd_valid_i) |=> nvm_rd_o) else $error("no read strobe");
  // Readout opcode enters sending with twenty bytes.
  AST_READOUT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_IDLE && cmd_valid_i && cmd_byte_i == `BICD_OP_READOUT) |=>
    cur.st == BICD_SEND && cur.rsp_len == `BICD_READOUT_LEN) else $error("readout not started");
  // Channel 0 one-hot matches its field of the excitation byte.
  AST_EXC_DEC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    exc_onehot_o[3:0] == (4'h1 << excitation_o[1:0])) else $error("excitation decode wrong");
  // The assertions below tie each action to the outputs it must leave behind.
  // They are written against the state register so that a wrong decode shows at the edge where it happens.
  // A failure names the rule that broke, which keeps the search short when a bench row goes wrong.
  // Speed bit lands on the addressed channel from bit 19 of the assembled value.
  // Bit 19 sits eight places higher in the shift register while the last byte is still on the bus.
  AST_SPEED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_CFG && cmd_valid_i && cur.cfg_cnt == `BICD_CFG_BYTES - 3'h1) |=>
    cur.conv[$past(cur.chan)].speed_mult == $past(cur.cfg[`BICD_SPEED_BIT + 8])) else $error("speed bit wrong");
  // Memory read data is passed on unchanged in the cycle after it arrives.
  // The reply path must be free, otherwise the byte is not taken and the decoder waits for nvm_rvalid_i again.
  AST_RD_REPLY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_SEND && cur.is_rd && rsp_ready_i && !cur.rsp_valid && nvm_rvalid_i) |=>
    rsp_valid_o && rsp_byte_o == $past(nvm_rdata_i)) else $error("memory read reply wrong");
  // The excitation byte is stored whole when its parameter arrives.
  AST_EXC_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_EXC && cmd_valid_i) |=> excitation_o == $past(cmd_byte_i))
    else $error("excitation not stored");
  // A readout keeps the decoder busy until its last byte has left.
  AST_BUSY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_IDLE && cmd_valid_i && cmd_byte_i == `BICD_OP_READOUT) |=> busy_o)
    else $error("busy missing during readout");
  // A write strobe only ever follows a data byte, never an address or a read.
  // A stray strobe would cost a slow memory write and could overwrite calibration data.
  AST_WR_SRC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    nvm_wr_o |-> $past(cur.st) == BICD_DATA) else $error("stray memory write");
  // Sample numbers follow the words and are never formatted like them.
  AST_SAMPLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (cur.st == BICD_SEND && !cur.is_rd && rsp_ready_i && !cur.rsp_valid && cur.rsp_idx >= `BICD_WORD_BYTES) |=>
    rsp_valid_o) else $error("sample number not sent");
  // Main scenarios that the bench is expected to reach.
  COV_READOUT: cover property (@(posedge ref_clk_i) cur.st == BICD_SEND && !cur.is_rd);
  COV_CFG: cover property (@(posedge ref_clk_i) cur.st == BICD_CFG && cmd_valid_i && cur.cfg_cnt == 3'h3);
  COV_EXC: cover property (@(posedge ref_clk_i) cur.st == BICD_EXC && cmd_valid_i);
  COV_WRITE: cover property (@(posedge ref_clk_i) nvm_wr_o);
  COV_READ: cover property (@(posedge ref_clk_i) nvm_rd_o);
endmodule : bicd_core

// ===== core/bicd_defs.svh
// Constant definitions for the bridge input command decoder.
// Assumes inclusion by bare name from the package file, whose macros the core module also uses.
`ifndef BICD_DEFS_SVH
`define BICD_DEFS_SVH
`define BICD_OP_CONV_CFG 8'h00
`define BICD_OP_READOUT 8'h01
`define BICD_OP_EXC_SEL 8'h02
`define BICD_OP_NVM_RD 8'h0d
`define BICD_OP_NVM_WR 8'h0e
`define BICD_CHAN_MSB 1
`define BICD_OSR_MSB 31
`define BICD_OSR_LSB 20
`define BICD_SPEED_BIT 19
`define BICD_RSV_MSB 18
`define BICD_OSR_CODE_LO 12'ha01
`define BICD_OSR_CODE_HI 12'ha09
`define BICD_OSR_CODE_MAX 12'ha0f
`define BICD_OSR_IDX_MAX 4'ha
`define BICD_EXC_RESET 8'h00
`define BICD_READOUT_LEN 5'h14
`define BICD_WORD_BYTES 5'h10
`define BICD_RSP_MAX 5'h1a
`define BICD_CFG_BYTES 3'h4
`endif

// ===== core/bicd_pkg.sv
// Types shared by the bridge input command decoder.
// Assumes the constant header is on the include path.
`include "bicd_defs.svh"
package bicd_pkg;
  // Decoder states.
  typedef enum logic [2:0] {
    BICD_IDLE,
    BICD_CHAN,
    BICD_CFG,
    BICD_EXC,
    BICD_ADDR,
    BICD_DATA,
    BICD_SEND
  } bicd_state_e;

  // Per-channel conversion setting.
  typedef struct packed {
    logic [3:0] osr_idx;
    logic speed_mult;
  } bicd_conv_s;

  // Request to the calibration memory.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } bicd_nvm_s;
endpackage : bicd_pkg

// ===== verif/bicd_gateway_model.sv
// Model of the gateway that sends command lists, plus the calibration memory.
// Assumes the bench calls its tasks just after a rising edge of the shared clock.
`timescale 1ns/100ps
module bicd_gateway_model (
  input wire logic ref_clk_i,
  input wire logic nvm_rd_i,
  input wire logic nvm_wr_i,
  input wire logic [7:0] nvm_addr_i,
  input wire logic [7:0] nvm_wdata_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_byte_o,
  output logic rsp_ready_o,
  output logic [7:0] nvm_rdata_o,
  output logic nvm_rvalid_o
);
  logic [7:0] mem [256]; // Calibration bytes, preset to a known pattern.
  logic [7:0] rd_addr; // Address held while a read is pending.

  // Idle levels at time zero and a memory image the bench can predict.
  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o = 8'h00;
    rsp_ready_o = 1'b1;
    nvm_rdata_o = 8'h00;
    nvm_rvalid_o = 1'b0;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
  end

  // Sends one list back to back; the released lane shows the inverse so stale data never looks valid.
  task automatic send(input logic [7:0] q [$]);
    foreach (q[i]) begin
      cmd_valid_o = 1'b1;
      cmd_byte_o = q[i];
      @(posedge ref_clk_i);
      #1;
    end
    cmd_valid_o = 1'b0;
    cmd_byte_o = ~cmd_byte_o;
  endtask : send

  // Lets the bench stall or release the reply path.
  task automatic set_ready(input logic r);
    rsp_ready_o = r;
  endtask : set_ready

  // Reads answer three cycles late, as a slow part would; writes land at once.
  always @(posedge ref_clk_i) begin
    if (nvm_wr_i === 1'b1) mem[nvm_addr_i] = nvm_wdata_i;
    if (nvm_rd_i === 1'b1) begin
      rd_addr = nvm_addr_i;
      repeat (3) @(posedge ref_clk_i);
      #1;
      nvm_rvalid_o = 1'b1;
      nvm_rdata_o = mem[rd_addr];
      @(posedge ref_clk_i);
      #1;
      nvm_rvalid_o = 1'b0;
      nvm_rdata_o = ~nvm_rdata_o;
    end
  end
endmodule : bicd_gateway_model

// ===== verif/test_bridge_input_command_decoder.sv
// Self-checking bench for the command decoder.
// Assumes the gateway model stands on the command side and the design asserts its own rules.
`timescale 1ns/100ps
module test_bridge_input_command_decoder
  import bicd_pkg::*;
;
  typedef struct packed {logic [11:0] code; logic [3:0] idx;} bicd_row_s;
  // Oversample codes beside the index each should give; the last two are not valid codes.
  localparam bicd_row_s ROWS [12] = '{'{12'ha01, 4'h1}, '{12'ha02, 4'h2}, '{12'ha03, 4'h3}, '{12'ha04, 4'h4},
    '{12'ha05, 4'h5}, '{12'ha06, 4'h6}, '{12'ha07, 4'h7}, '{12'ha08, 4'h8}, '{12'ha09, 4'h9},
    '{12'ha0f, 4'ha}, '{12'ha0a, 4'h0}, '{12'h000, 4'h0}};
  // Excitation bytes, each predicted field by field by the onehot function.
  localparam logic [7:0] EXC_ROWS [4] = '{8'he4, 8'h1b, 8'hff, 8'h00};
  logic ref_clk = 1'b0, rst = 1'b1, cmd_valid, rsp_ready, nvm_rvalid, rsp_valid, busy, common_valid;
  logic nvm_rd, nvm_wr;
  logic [7:0] cmd_byte, nvm_rdata, rsp_byte, common_byte, excitation, nvm_addr, nvm_wdata, last_common;
  logic [127:0] conv_word = {32'hd234_5678, 32'h2a5a_5a5a, 32'h0abc_def0, 32'h3123_4567};
  logic [31:0] sample_num = 32'hd4c3b2a1, v;
  logic [19:0] conv_cfg;
  logic [15:0] exc_onehot, oh;
  logic [7:0] rsp_q [$]; // Reply bytes in arrival order.
  int err_count = 0, n_compared = 0;

  always #2 ref_clk = ~ref_clk; // 250 MHz.

  bicd_core u_bicd_core (.ref_clk_i(ref_clk), .rst_i(rst), .cmd_valid_i(cmd_valid), .cmd_byte_i(cmd_byte),
    .rsp_ready_i(rsp_ready), .conv_word_i(conv_word), .sample_num_i(sample_num), .nvm_rdata_i(nvm_rdata),
    .nvm_rvalid_i(nvm_rvalid), .rsp_byte_o(rsp_byte), .rsp_valid_o(rsp_valid), .busy_o(busy),
    .common_valid_o(common_valid), .common_byte_o(common_byte), .conv_cfg_o(conv_cfg),
    .excitation_o(excitation), .exc_onehot_o(exc_onehot), .nvm_rd_o(nvm_rd), .nvm_wr_o(nvm_wr),
    .nvm_addr_o(nvm_addr), .nvm_wdata_o(nvm_wdata));
  bicd_gateway_model u_bicd_gateway_model (.ref_clk_i(ref_clk), .nvm_rd_i(nvm_rd), .nvm_wr_i(nvm_wr),
    .nvm_addr_i(nvm_addr), .nvm_wdata_i(nvm_wdata), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
    .rsp_ready_o(rsp_ready), .nvm_rdata_o(nvm_rdata), .nvm_rvalid_o(nvm_rvalid));

  // Reply bytes and forwarded opcodes are single-cycle pulses, so they are caught at every edge.
  always @(posedge ref_clk) begin
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_byte);
    if (common_valid === 1'b1) last_common = common_byte;
  end

  task automatic finish_test();
    if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Waits, bounded, until the decoder is idle and its last reply pulse has landed.
  task automatic wait_idle();
    int n;
    for (n = 0; n < 400 && busy !== 1'b0; n++) @(posedge ref_clk) #1;
    if (n == 400) begin
      chk("busy timeout", 32'h1, 32'h0);
      finish_test();
    end
    repeat (2) @(posedge ref_clk) #1;
  endtask : wait_idle

  task automatic run(input logic [7:0] q [$]);
    u_bicd_gateway_model.send(q);
    wait_idle();
  endtask : run

  // Predicts the one-hot supply select for an excitation byte.
  function automatic logic [15:0] onehot(input logic [7:0] b);
    onehot = 16'h0000;
    for (int c = 0; c < 4; c++) onehot[c*4 + b[c*2 +: 2]] = 1'b1;
  endfunction : onehot

  initial begin
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    chk("reset exc", {exc_onehot, excitation}, {16'h1111, 8'h00});
    chk("reset cfg", conv_cfg, 32'h0);
    // Channel upper bits and reserved config bits are kept clear by the sender.
    foreach (ROWS[i]) begin
      v = {ROWS[i].code, 1'(i), 19'h0};
      run('{8'h00, 8'(i % 4), v[7:0], v[15:8], v[23:16], v[31:24]});
      chk("cfg", conv_cfg[(i%4)*5 +: 5], {ROWS[i].idx, 1'(i)});
    end
    chk("cfg silent", rsp_q.size(), 0);
    foreach (EXC_ROWS[i]) begin
      v[7:0] = EXC_ROWS[i];
      run('{8'h02, v[7:0]});
      chk("exc", {exc_onehot, excitation}, {onehot(v[7:0]), v[7:0]});
    end
    // An unknown opcode goes to the shared logic and leaves settings alone.
    run('{8'h02, 8'h9c});
    v = conv_cfg;
    run('{8'h55});
    chk("common", last_common, 8'h55);
    chk("exc held", {exc_onehot, excitation}, {onehot(8'h9c), 8'h9c});
    chk("cfg held", conv_cfg, v);
    // Readout begins under a stall; nothing may leave until the sink is ready.
    u_bicd_gateway_model.set_ready(1'b0);
    u_bicd_gateway_model.send('{8'h01});
    repeat (10) @(posedge ref_clk) #1;
    chk("stall", rsp_q.size(), 0);
    u_bicd_gateway_model.set_ready(1'b1);
    wait_idle();
    chk("readout len", rsp_q.size(), 20);
    // The top two bits of every word read as zero, whatever the converter delivered.
    for (int i = 0; i < 20 && i < rsp_q.size(); i++)
      if (i < 16) chk("word byte", rsp_q[i], conv_word[(i/4)*32 + (i%4)*8 +: 8] & ((i%4 == 3) ? 8'h3f : 8'hff));
      else chk("sample", rsp_q[i], sample_num[(i-16)*8 +: 8]);
    for (int i = 3; i < 16 && i < rsp_q.size(); i += 4) chk("top bits", rsp_q[i][7:6], 0);
    // One memory write per list, then read back and read an untouched byte.
    run('{8'h0e, 8'h33, 8'hc6});
    rsp_q.delete();
    run('{8'h0d, 8'h33});
    run('{8'h0d, 8'h10});
    chk("nvm len", rsp_q.size(), 2);
    chk("nvm data", {rsp_q[0], rsp_q[1]}, {8'hc6, 8'h4a});
    // A reset in mid-run returns every supply to the lowest setting.
    run('{8'h02, 8'hff});
    rst = 1'b1;
    @(posedge ref_clk) #1;
    rst = 1'b0;
    chk("rerst exc", {exc_onehot, excitation}, {16'h1111, 8'h00});
    chk("rerst cfg", conv_cfg, 32'h0);
    finish_test();
  end
endmodule : test_bridge_input_command_decoder
